// File: muc_pkg.sv
// shared constants and types for the mini uart control registers
package muc_pkg;

   // -----------------------------------------------------------------
   // register byte addresses
   // -----------------------------------------------------------------
   localparam logic [31:0] MUC_ADDR_DATA = 32'h7e215040;
   localparam logic [31:0] MUC_ADDR_IER = 32'h7e215044;
   localparam logic [31:0] MUC_ADDR_IIR = 32'h7e215048;
   localparam logic [31:0] MUC_ADDR_LCR = 32'h7e21504c;
   localparam logic [31:0] MUC_ADDR_MCR = 32'h7e215050;

   // -----------------------------------------------------------------
   // field positions
   // -----------------------------------------------------------------
   localparam int MUC_IER_RX_BIT = 0;
   localparam int MUC_IER_TX_BIT = 1;
   localparam int MUC_IIR_PEND_BIT = 0;
   localparam int MUC_IIR_ID_LSB = 1;
   localparam int MUC_IIR_RXCLR_BIT = 1;
   localparam int MUC_IIR_TXCLR_BIT = 2;
   localparam int MUC_LCR_SIZE_LSB = 0;
   localparam int MUC_LCR_BRK_BIT = 6;
   localparam int MUC_LCR_DIVISOR_LATCH_ACCESS_BIT = 7;
   localparam int MUC_MCR_RTS_BIT = 1;

   // -----------------------------------------------------------------
   // fixed read values and reset values
   // -----------------------------------------------------------------
   localparam logic [1:0] MUC_IIR_FIFO_EN = 2'h3;
   localparam logic [2:0] MUC_IIR_ZERO_BITS = 3'h0;
   localparam logic [1:0] MUC_SIZE_8BIT = 2'h3;
   localparam logic [1:0] MUC_SIZE_RST = 2'h0;
   localparam logic [15:0] MUC_DIV_RST = 16'h0000;
   localparam logic [7:0] MUC_BYTE_RST = 8'h00;
   localparam int MUC_OVERSAMPLE = 8;

   // -----------------------------------------------------------------
   // interrupt cause codes
   // -----------------------------------------------------------------
   typedef enum logic [1:0] {
      MUC_CAUSE_NONE = 2'b00,
      MUC_CAUSE_THR = 2'b01,
      MUC_CAUSE_RX = 2'b10
   } muc_cause_type;

endpackage : muc_pkg

// File: muc_baud_gen.sv
// oversample tick generator driven by the 16-bit baud divisor
`timescale 1ns/10ps

module muc_baud_gen
   import muc_pkg::*;
#(
   parameter int DIV_W = 16
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic [DIV_W-1:0] divisor,
   output logic sample_tick
);

   logic [DIV_W-1:0] count_q;
   logic [DIV_W-1:0] gap_q;
   logic [DIV_W-1:0] div_at_tick_q;
   logic gap_valid_q;

   // one tick every divisor+1 clocks; a bit lasts eight ticks
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         count_q <= DIV_W'(MUC_DIV_RST);
         sample_tick <= 1'b0;
      end else if (count_q == '0) begin
         count_q <= divisor;
         sample_tick <= 1'b1;
      end else begin
         count_q <= count_q - 1'b1;
         sample_tick <= 1'b0;
      end
   end

   // helper for checking tick spacing
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         gap_q <= '0;
         div_at_tick_q <= '0;
         gap_valid_q <= 1'b0;
      end else if (count_q == '0) begin
         gap_q <= '0;
         div_at_tick_q <= divisor;
         gap_valid_q <= 1'b1;
      end else begin
         gap_q <= gap_q + 1'b1;
      end
   end

   a_tick_spacing: assert property (@(posedge hclk) disable iff (!hresetn)
      (count_q == '0 && gap_valid_q) |-> (gap_q == div_at_tick_q) ##1 sample_tick)
      else $error("oversample tick spacing differs from divisor plus one");

endmodule : muc_baud_gen

// File: muc_irq_ident.sv
// interrupt cause encoder with receive priority
`timescale 1ns/10ps

module muc_irq_ident
   import muc_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic rx_irq_en,
   input wire logic tx_irq_en,
   input wire logic rx_fifo_not_empty,
   input wire logic tx_fifo_not_full,
   output muc_cause_type cause_q,
   output logic pending_n_q
);

   logic rx_cause;
   logic tx_cause;

   assign rx_cause = rx_irq_en && rx_fifo_not_empty;
   assign tx_cause = tx_irq_en && tx_fifo_not_full;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cause_q <= MUC_CAUSE_NONE;
         pending_n_q <= 1'b1;
      end else begin
         pending_n_q <= !(rx_cause || tx_cause);
         if (rx_cause) begin
            cause_q <= MUC_CAUSE_RX;
         end else if (tx_cause) begin
            cause_q <= MUC_CAUSE_THR;
         end else begin
            cause_q <= MUC_CAUSE_NONE;
         end
      end
   end

   a_rx_first: assert property (@(posedge hclk) disable iff (!hresetn)
      (rx_cause && tx_cause) |=> (cause_q == MUC_CAUSE_RX && !pending_n_q))
      else $error("receive cause not reported first");

   a_pend_matches: assert property (@(posedge hclk) disable iff (!hresetn)
      pending_n_q == (cause_q == MUC_CAUSE_NONE))
      else $error("pending flag disagrees with cause code");

endmodule : muc_irq_ident

// File: muc_ctrl_regs.sv
// mini uart control registers behind an ahb-lite slave
//
// Our own choice: the AHB-Lite slave port.
`timescale 1ns/10ps

// Contract
// - with divisor access set, the enable slot holds divisor bits 15:8.
// - receive enable plus non-empty receive fifo asserts the interrupt.
// - enable bit 1 gates transmit interrupts, read/write, resets to zero.
// - identification bits 7:6 always read one.
// - identification bits 5:3 always read zero.
// - identification bits 2:1 give cause: 00 none, 01 transmit, 10 receive.
// - writing identification bit 1 flushes receive fifo, bit 2 transmit fifo.
// - identification bit 0 is low while an enabled interrupt pends.
// - line control bit 7 maps first two slots onto the divisor.
// - line control bit 6 forces the transmit line low.
// - line control bits 1:0 select seven (00) or eight (11) data bits.
// - modem control bit 1 drives request-to-send inverted.
// - automatic flow control overrides the software request-to-send bit.
// - reserved bits accept writes without effect.
// - with divisor access set, the data slot holds divisor bits 7:0.
// - eight-times oversampling, bit rate is clock over eight times divisor plus one.
module muc_ctrl_regs
   import muc_pkg::*;
#(
   parameter int DIV_W = 16
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic [7:0] rx_fifo_rdata,
   input wire logic rx_fifo_not_empty,
   input wire logic tx_fifo_not_full,
   input wire logic tx_shift_line,
   input wire logic auto_rts_enable,
   input wire logic auto_rts_level,
   output logic rx_fifo_pop,
   output logic tx_fifo_push_q,
   output logic [7:0] tx_fifo_wdata_q,
   output logic rx_fifo_flush_q,
   output logic tx_fifo_flush_q,
   output logic eight_bit_mode_q,
   output logic sample_tick,
   output logic serial_tx_line,
   output logic request_to_send_line,
   output logic uart_irq
);

   // -----------------------------------------------------------------
   // bus data phase tracking
   // -----------------------------------------------------------------
   logic dp_valid_q;
   logic dp_write_q;
   logic [31:0] dp_addr_q;
   logic addr_take;

   assign addr_take = hsel && htrans[1] && hready;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dp_valid_q <= 1'b0;
         dp_write_q <= 1'b0;
         dp_addr_q <= '0;
      end else begin
         dp_valid_q <= addr_take;
         if (addr_take) begin
            dp_write_q <= hwrite;
            dp_addr_q <= haddr;
         end
      end
   end

   logic sel_data;
   logic sel_ier;
   logic sel_iir;
   logic sel_lcr;
   logic sel_mcr;
   logic wr_dp;
   logic rd_dp;

   assign sel_data = dp_addr_q[31:2] == MUC_ADDR_DATA[31:2];
   assign sel_ier = dp_addr_q[31:2] == MUC_ADDR_IER[31:2];
   assign sel_iir = dp_addr_q[31:2] == MUC_ADDR_IIR[31:2];
   assign sel_lcr = dp_addr_q[31:2] == MUC_ADDR_LCR[31:2];
   assign sel_mcr = dp_addr_q[31:2] == MUC_ADDR_MCR[31:2];
   assign wr_dp = dp_valid_q && dp_write_q;
   assign rd_dp = dp_valid_q && !dp_write_q;

   // -----------------------------------------------------------------
   // control registers
   // -----------------------------------------------------------------
   logic [DIV_W-1:0] divisor_q;
   logic ier_rx_q;
   logic ier_tx_q;
   logic divisor_latch_access_q;
   logic break_q;
   logic [1:0] data_size_q;
   logic mcr_rts_q;

   // reserved bits are simply not stored
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ier_rx_q <= 1'b0;
         ier_tx_q <= 1'b0;
      end else if (wr_dp && sel_ier && !divisor_latch_access_q) begin
         ier_rx_q <= hwdata[MUC_IER_RX_BIT];
         ier_tx_q <= hwdata[MUC_IER_TX_BIT];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         divisor_q <= DIV_W'(MUC_DIV_RST);
      end else if (wr_dp && divisor_latch_access_q && sel_ier) begin
         divisor_q[DIV_W-1:8] <= hwdata[DIV_W-1-8:0];
      end else if (wr_dp && divisor_latch_access_q && sel_data) begin
         divisor_q[7:0] <= hwdata[7:0];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         divisor_latch_access_q <= 1'b0;
         break_q <= 1'b0;
         data_size_q <= MUC_SIZE_RST;
      end else if (wr_dp && sel_lcr) begin
         divisor_latch_access_q <= hwdata[MUC_LCR_DIVISOR_LATCH_ACCESS_BIT];
         break_q <= hwdata[MUC_LCR_BRK_BIT];
         data_size_q <= hwdata[MUC_LCR_SIZE_LSB +: 2];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mcr_rts_q <= 1'b0;
      end else if (wr_dp && sel_mcr) begin
         mcr_rts_q <= hwdata[MUC_MCR_RTS_BIT];
      end
   end

   // only 11 selects eight bits; other codes fall back to seven
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         eight_bit_mode_q <= 1'b0;
      end else begin
         eight_bit_mode_q <= data_size_q == MUC_SIZE_8BIT;
      end
   end

   // -----------------------------------------------------------------
   // fifo strobes
   // -----------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rx_fifo_flush_q <= 1'b0;
         tx_fifo_flush_q <= 1'b0;
      end else begin
         rx_fifo_flush_q <= wr_dp && sel_iir && hwdata[MUC_IIR_RXCLR_BIT];
         tx_fifo_flush_q <= wr_dp && sel_iir && hwdata[MUC_IIR_TXCLR_BIT];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tx_fifo_push_q <= 1'b0;
         tx_fifo_wdata_q <= MUC_BYTE_RST;
      end else begin
         tx_fifo_push_q <= wr_dp && sel_data && !divisor_latch_access_q;
         if (wr_dp && sel_data && !divisor_latch_access_q) begin
            tx_fifo_wdata_q <= hwdata[7:0];
         end
      end
   end

   // the head byte is shown during the data phase and popped at its end
   assign rx_fifo_pop = rd_dp && sel_data && !divisor_latch_access_q && rx_fifo_not_empty;

   // -----------------------------------------------------------------
   // interrupt identification and baud timing
   // -----------------------------------------------------------------
   muc_cause_type cause_q;
   logic pending_n_q;

   muc_irq_ident u_ident (
      .hclk(hclk),
      .hresetn(hresetn),
      .rx_irq_en(ier_rx_q),
      .tx_irq_en(ier_tx_q),
      .rx_fifo_not_empty(rx_fifo_not_empty),
      .tx_fifo_not_full(tx_fifo_not_full),
      .cause_q(cause_q),
      .pending_n_q(pending_n_q)
   );

   assign uart_irq = !pending_n_q;

   muc_baud_gen #(
      .DIV_W(DIV_W)
   ) u_baud (
      .hclk(hclk),
      .hresetn(hresetn),
      .divisor(divisor_q),
      .sample_tick(sample_tick)
   );

   // -----------------------------------------------------------------
   // line outputs
   // -----------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         serial_tx_line <= 1'b1;
         request_to_send_line <= 1'b1;
      end else begin
         serial_tx_line <= break_q ? 1'b0 : tx_shift_line;
         if (auto_rts_enable) begin
            request_to_send_line <= auto_rts_level;
         end else begin
            request_to_send_line <= !mcr_rts_q;
         end
      end
   end

   // -----------------------------------------------------------------
   // read mux
   // -----------------------------------------------------------------
   always_comb begin
      hrdata = 32'h00000000;
      if (rd_dp) begin
         if (sel_data) begin
            hrdata[7:0] = divisor_latch_access_q ? divisor_q[7:0] : rx_fifo_rdata;
         end else if (sel_ier) begin
            if (divisor_latch_access_q) begin
               hrdata[7:0] = divisor_q[DIV_W-1:8];
            end else begin
               hrdata[MUC_IER_RX_BIT] = ier_rx_q;
               hrdata[MUC_IER_TX_BIT] = ier_tx_q;
            end
         end else if (sel_iir) begin
            hrdata[7:6] = MUC_IIR_FIFO_EN;
            hrdata[5:3] = MUC_IIR_ZERO_BITS;
            hrdata[MUC_IIR_ID_LSB +: 2] = cause_q;
            hrdata[MUC_IIR_PEND_BIT] = pending_n_q;
         end else if (sel_lcr) begin
            hrdata[MUC_LCR_DIVISOR_LATCH_ACCESS_BIT] = divisor_latch_access_q;
            hrdata[MUC_LCR_BRK_BIT] = break_q;
            hrdata[MUC_LCR_SIZE_LSB +: 2] = data_size_q;
         end else if (sel_mcr) begin
            hrdata[MUC_MCR_RTS_BIT] = mcr_rts_q;
         end
      end
   end

   // -----------------------------------------------------------------
   // checks
   // -----------------------------------------------------------------
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   sequence s_ier_write_divisor_latch_access;
      wr_dp && sel_ier && divisor_latch_access_q;
   endsequence

   sequence s_ier_write_plain;
      wr_dp && sel_ier && !divisor_latch_access_q;
   endsequence

   a_div_high_write: assert property (s_ier_write_divisor_latch_access |=> divisor_q[15:8] == $past(hwdata[7:0]) &&
      ier_tx_q == $past(ier_tx_q))
      else $error("divisor high byte not written through enable slot");

   a_div_low_read: assert property ((rd_dp && sel_data && divisor_latch_access_q) |-> hrdata == {24'h000000, divisor_q[7:0]})
      else $error("data slot did not return divisor low byte");

   a_tx_enable_write: assert property (s_ier_write_plain |=> ier_tx_q == $past(hwdata[1]) &&
      divisor_q == $past(divisor_q))
      else $error("transmit enable not stored");

   a_rx_irq_raise: assert property ((ier_rx_q && rx_fifo_not_empty) |=> uart_irq)
      else $error("receive interrupt missing");

   a_no_irq_idle: assert property ((!ier_rx_q && !(ier_tx_q && tx_fifo_not_full)) |=> !uart_irq ##0
      cause_q == MUC_CAUSE_NONE)
      else $error("interrupt raised without enabled cause");

   a_iir_fixed_bits: assert property ((rd_dp && sel_iir) |-> hrdata[7:3] == 5'h18 &&
      hrdata[2:1] != 2'h3)
      else $error("identification fixed bits wrong");

   a_flush_pulse: assert property ((wr_dp && sel_iir) |=> rx_fifo_flush_q == $past(hwdata[1]) &&
      tx_fifo_flush_q == $past(hwdata[2]))
      else $error("fifo flush strobe mismatch");

   a_break_low: assert property (break_q |=> !serial_tx_line)
      else $error("break did not hold transmit line low");

   a_rts_drive: assert property (!auto_rts_enable |=> request_to_send_line == !$past(mcr_rts_q))
      else $error("request-to-send not inverse of control bit");

   a_rts_auto: assert property (auto_rts_enable |=> request_to_send_line == $past(auto_rts_level))
      else $error("automatic flow level not driven");

   a_push_blocked: assert property ((wr_dp && sel_data && divisor_latch_access_q) |=> !tx_fifo_push_q)
      else $error("transmit push issued under divisor access");

   a_push_byte: assert property ((wr_dp && sel_data && !divisor_latch_access_q) |=> tx_fifo_push_q &&
      tx_fifo_wdata_q == $past(hwdata[7:0]))
      else $error("transmit byte not pushed");

   a_pop_gate: assert property ((rd_dp && sel_data && divisor_latch_access_q) |-> !rx_fifo_pop &&
      hrdata[31:8] == 24'h000000)
      else $error("receive pop issued under divisor access");

   a_div_high_read: assert property ((rd_dp && sel_ier && divisor_latch_access_q) |->
      hrdata == {24'h000000, divisor_q[DIV_W-1:8]})
      else $error("enable slot did not return divisor high byte");

   a_size_seven: assert property ((data_size_q == 2'h0) |=> !eight_bit_mode_q)
      else $error("seven bit size not decoded");

   a_size_eight: assert property ((data_size_q == MUC_SIZE_8BIT) |=> eight_bit_mode_q)
      else $error("eight bit size not decoded");

   a_ier_reserved: assert property ((rd_dp && sel_ier && !divisor_latch_access_q) |->
      hrdata[31:2] == 30'h00000000)
      else $error("enable slot reserved bits not zero");

   a_lcr_reserved: assert property ((rd_dp && sel_lcr) |->
      hrdata[5:2] == 4'h0 && hrdata[31:8] == 24'h000000)
      else $error("line control reserved bits not zero");

   a_mcr_reserved: assert property ((rd_dp && sel_mcr) |->
      hrdata[31:2] == 30'h00000000 && hrdata[0] == 1'b0)
      else $error("modem control reserved bits not zero");

endmodule : muc_ctrl_regs

// File: muc_remote_model.sv
// behavioural model of the fifos and shifter that sit beside the control block
`timescale 1ns/10ps

module muc_remote_model (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic rx_load,
   input wire logic [7:0] rx_load_byte,
   input wire logic rx_fifo_pop,
   input wire logic rx_fifo_flush_q,
   input wire logic tx_fifo_push_q,
   input wire logic [7:0] tx_fifo_wdata_q,
   input wire logic tx_fifo_flush_q,
   output logic [7:0] rx_fifo_rdata,
   output logic rx_fifo_not_empty,
   output logic tx_fifo_not_full,
   output logic tx_shift_line,
   output logic [3:0] tx_count,
   output logic [7:0] tx_last
);
   logic [7:0] mem_q [8];
   logic [3:0] wr_q;
   logic [3:0] rd_q;
   logic [7:0] gone_q;

   // an empty fifo shows the inverse of the byte last taken, never a stale copy
   assign rx_fifo_not_empty = (wr_q != rd_q);
   assign rx_fifo_rdata = rx_fifo_not_empty ? mem_q[rd_q[2:0]] : ~gone_q;
   assign tx_fifo_not_full = (tx_count < 4'h8);
   // shifter stays idle, so the line rests high
   assign tx_shift_line = 1'b1;

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_q <= 4'h0;
         rd_q <= 4'h0;
         gone_q <= 8'h00;
         tx_count <= 4'h0;
         tx_last <= 8'h00;
      end else begin
         if (rx_fifo_flush_q) begin
            rd_q <= wr_q;
         end else if (rx_fifo_pop && rx_fifo_not_empty) begin
            gone_q <= mem_q[rd_q[2:0]];
            rd_q <= rd_q + 4'h1;
         end
         if (rx_load) begin
            mem_q[wr_q[2:0]] <= rx_load_byte;
            wr_q <= wr_q + 4'h1;
         end
         if (tx_fifo_flush_q) begin
            tx_count <= 4'h0;
         end else if (tx_fifo_push_q && tx_fifo_not_full) begin
            tx_count <= tx_count + 4'h1;
            tx_last <= tx_fifo_wdata_q;
         end
      end
   end
endmodule : muc_remote_model

// File: testbench.sv
// self-checking bench for the mini uart control registers
`timescale 1ns/10ps

module testbench;
   import muc_pkg::*;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic auto_rts_enable = 1'b0;
   logic auto_rts_level = 1'b0;
   logic rx_load = 1'b0;
   logic [7:0] rx_load_byte = 8'h00;
   logic [31:0] hrdata, rd;
   logic hreadyout, hresp, rx_fifo_pop, tx_fifo_push_q, rx_fifo_flush_q, tx_fifo_flush_q;
   logic rx_fifo_not_empty, tx_fifo_not_full, tx_shift_line, eight_bit_mode_q, sample_tick;
   logic serial_tx_line, request_to_send_line, uart_irq;
   logic [7:0] rx_fifo_rdata, tx_fifo_wdata_q, tx_last;
   logic [3:0] tx_count;
   logic [31:0] ra [5] = '{MUC_ADDR_IER, MUC_ADDR_IIR, MUC_ADDR_LCR, MUC_ADDR_MCR, 32'h7e215100};
   logic [31:0] rv [5] = '{32'h0, 32'hc1, 32'h0, 32'h0, 32'h0};
   int bad_count = 0;
   int checked = 0;
   int n;

   always #20 hclk = ~hclk;

   muc_ctrl_regs muc_ctrl_regs_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .rx_fifo_rdata(rx_fifo_rdata),
      .rx_fifo_not_empty(rx_fifo_not_empty), .tx_fifo_not_full(tx_fifo_not_full),
      .tx_shift_line(tx_shift_line), .auto_rts_enable(auto_rts_enable), .auto_rts_level(auto_rts_level),
      .rx_fifo_pop(rx_fifo_pop), .tx_fifo_push_q(tx_fifo_push_q), .tx_fifo_wdata_q(tx_fifo_wdata_q),
      .rx_fifo_flush_q(rx_fifo_flush_q), .tx_fifo_flush_q(tx_fifo_flush_q),
      .eight_bit_mode_q(eight_bit_mode_q), .sample_tick(sample_tick), .serial_tx_line(serial_tx_line),
      .request_to_send_line(request_to_send_line), .uart_irq(uart_irq));

   muc_remote_model muc_remote_model_i (.hclk(hclk), .hresetn(hresetn), .rx_load(rx_load),
      .rx_load_byte(rx_load_byte), .rx_fifo_pop(rx_fifo_pop), .rx_fifo_flush_q(rx_fifo_flush_q),
      .tx_fifo_push_q(tx_fifo_push_q), .tx_fifo_wdata_q(tx_fifo_wdata_q), .tx_fifo_flush_q(tx_fifo_flush_q),
      .rx_fifo_rdata(rx_fifo_rdata), .rx_fifo_not_empty(rx_fifo_not_empty),
      .tx_fifo_not_full(tx_fifo_not_full), .tx_shift_line(tx_shift_line), .tx_count(tx_count),
      .tx_last(tx_last));

   task automatic complete_run();
      $display("checks %0d errors %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : complete_run

   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
      checked++;
      if (got !== exp) begin
         bad_count++;
         $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : check

   // one single transfer; entered and left right after a rising edge
   task automatic bus_xfer(input logic [31:0] a, input logic w, input logic [31:0] wd);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      htrans <= 2'h2;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= wd;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      rd = hrdata;
   endtask : bus_xfer

   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      bus_xfer(a, 1'b1, d);
   endtask : wr

   task automatic rdc(input logic [31:0] a, input logic [31:0] exp);
      bus_xfer(a, 1'b0, 32'h0);
      check(rd, exp, "register read");
   endtask : rdc

   task automatic cycles(input int k);
      repeat (k) @(posedge hclk);
   endtask : cycles

   task automatic wait_tick();
      n = 0;
      @(posedge hclk);
      while (sample_tick !== 1'b1 && n < 10000) begin
         @(posedge hclk);
         n++;
      end
   endtask : wait_tick

   task automatic load_rx(input logic [7:0] b);
      rx_load <= 1'b1;
      rx_load_byte <= b;
      @(posedge hclk);
      rx_load <= 1'b0;
      cycles(2);
   endtask : load_rx

   initial begin
      repeat (16) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      check({28'h0, serial_tx_line, request_to_send_line, uart_irq, eight_bit_mode_q}, 32'hc, "reset lines");
      wr(32'h7e215100, 32'hff);
      for (int i = 0; i < 5; i++) rdc(ra[i], rv[i]);
      // --------------------------------------------------------------
      // divisor overlay and baud ticks
      // --------------------------------------------------------------
      wr(MUC_ADDR_LCR, 32'h83);
      wr(MUC_ADDR_IER, 32'h12);
      rdc(MUC_ADDR_IER, 32'h12);
      wr(MUC_ADDR_IER, 32'h00);
      wr(MUC_ADDR_DATA, 32'h05);
      rdc(MUC_ADDR_DATA, 32'h05);
      rdc(MUC_ADDR_LCR, 32'h83);
      check({28'h0, tx_count}, 32'h0, "no push under divisor access");
      wait_tick();
      wait_tick();
      wait_tick();
      check(n + 1, 32'd6, "tick period");
      wr(MUC_ADDR_LCR, 32'h3f);
      rdc(MUC_ADDR_LCR, 32'h03);
      check({31'h0, eight_bit_mode_q}, 32'h1, "eight bit mode");
      wr(MUC_ADDR_LCR, 32'h00);
      cycles(2);
      check({31'h0, eight_bit_mode_q}, 32'h0, "seven bit mode");
      // --------------------------------------------------------------
      // break held beyond twelve bit times, then released
      // --------------------------------------------------------------
      wr(MUC_ADDR_LCR, 32'h40);
      cycles(2);
      n = 0;
      repeat (600) begin
         @(posedge hclk);
         if (serial_tx_line !== 1'b0) n++;
      end
      check(n, 32'h0, "break line low");
      wr(MUC_ADDR_LCR, 32'h00);
      cycles(2);
      check({31'h0, serial_tx_line}, 32'h1, "line idle after break");
      // --------------------------------------------------------------
      // request to send, software and automatic
      // --------------------------------------------------------------
      wr(MUC_ADDR_MCR, 32'h02);
      cycles(2);
      check({31'h0, request_to_send_line}, 32'h0, "rts low");
      auto_rts_enable <= 1'b1;
      auto_rts_level <= 1'b1;
      cycles(2);
      check({31'h0, request_to_send_line}, 32'h1, "auto rts high");
      auto_rts_level <= 1'b0;
      cycles(2);
      check({31'h0, request_to_send_line}, 32'h0, "auto rts low");
      auto_rts_enable <= 1'b0;
      wr(MUC_ADDR_MCR, 32'hfd);
      rdc(MUC_ADDR_MCR, 32'h00);
      check({31'h0, request_to_send_line}, 32'h1, "rts high");
      // --------------------------------------------------------------
      // interrupt causes, priority, fifo clears; divisor access stays clear
      // --------------------------------------------------------------
      wr(MUC_ADDR_IER, 32'h0d);
      rdc(MUC_ADDR_IER, 32'h01);
      rdc(MUC_ADDR_IIR, 32'hc1);
      load_rx(8'ha5);
      check({31'h0, uart_irq}, 32'h1, "rx irq");
      rdc(MUC_ADDR_IIR, 32'hc4);
      wr(MUC_ADDR_IER, 32'h0f);
      cycles(2);
      rdc(MUC_ADDR_IIR, 32'hc4);
      rdc(MUC_ADDR_DATA, 32'ha5);
      cycles(2);
      rdc(MUC_ADDR_IIR, 32'hc2);
      check({31'h0, uart_irq}, 32'h1, "tx irq");
      for (int i = 0; i < 8; i++) wr(MUC_ADDR_DATA, 32'h130 + i);
      cycles(2);
      check({20'h0, tx_count, tx_last}, 32'h837, "tx fifo filled");
      rdc(MUC_ADDR_IIR, 32'hc1);
      check({31'h0, uart_irq}, 32'h0, "no irq when full");
      wr(MUC_ADDR_IIR, 32'h04);
      cycles(2);
      check({28'h0, tx_count}, 32'h0, "tx flushed");
      rdc(MUC_ADDR_IIR, 32'hc2);
      wr(MUC_ADDR_IER, 32'h00);
      cycles(2);
      check({31'h0, uart_irq}, 32'h0, "tx irq gated");
      load_rx(8'h3c);
      load_rx(8'h3d);
      rdc(MUC_ADDR_IIR, 32'hc1);
      wr(MUC_ADDR_IER, 32'h01);
      cycles(2);
      check({31'h0, uart_irq}, 32'h1, "rx irq again");
      wr(MUC_ADDR_IIR, 32'h02);
      cycles(3);
      check({30'h0, rx_fifo_not_empty, uart_irq}, 32'h0, "rx flushed");
      rdc(MUC_ADDR_IIR, 32'hc1);
      check({31'h0, hresp}, 32'h0, "okay response");
      complete_run();
   end

   initial begin
      repeat (40000) @(posedge hclk);
      bad_count++;
      $display("Error at %0t: watchdog expired", $time);
      complete_run();
   end
endmodule : testbench
